// ### design/ccvb_defines.svh
`ifndef CCVB_DEFINES_SVH
`define CCVB_DEFINES_SVH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define CCVB_IDX_EVENT 14'h0803
`define CCVB_IDX_CC1_CHG 14'h0804
`define CCVB_IDX_CC2_CHG 14'h0805
`define CCVB_IDX_CC1_HITS 14'h0806
`define CCVB_IDX_CC2_HITS 14'h0807
`define CCVB_IDX_VBUS_HITS 14'h0808
`define CCVB_IDX_VBUS_CHG 14'h0809

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCVB_EV_VALID 7
`define CCVB_EV_RP 6
`define CCVB_EV_DETACH 5
`define CCVB_EV_ATTACH 4
`define CCVB_EV_SUM2 1
`define CCVB_EV_SUM1 0
`define CCVB_VBUS_SAFE0 0
`define CCVB_VBUS_MASK 8'h3d

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCVB_HITS_SRC_RST 8'hff
`define CCVB_HITS_SNK_RST 8'h00
`define CCVB_CHG_RST 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CCVB_CLK_PERIOD_NS 20
`define CCVB_STEP_SLOW_NS 1600000
`define CCVB_STEP_FAST_NS 100000
`define CCVB_STEP_SLOW_CYC (`CCVB_STEP_SLOW_NS / `CCVB_CLK_PERIOD_NS)
`define CCVB_STEP_FAST_CYC (`CCVB_STEP_FAST_NS / `CCVB_CLK_PERIOD_NS)

`endif

// ### design/ccvb_pkg.sv
package ccvb_pkg;

	typedef enum logic [1:0] {
		CCVB_PS_UNATTACHED = 2'b00,
		CCVB_PS_ATTACH_WAIT = 2'b01,
		CCVB_PS_ATTACHED_SRC = 2'b10,
		CCVB_PS_ATTACHED_SNK = 2'b11
	} ccvb_port_state_type;

	// channel 0 = cc pin 1, 1 = cc pin 2, 2 = vbus
	typedef struct packed {
		logic [2:0][7:0] sync1;
		logic [2:0][7:0] sync2;
		logic [2:0][7:0] hits;
		logic [2:0][7:0] target;
		logic [2:0][7:0] dbc_cnt;
		logic [2:0][7:0] chg;
		logic [16:0] prescale;
		logic tick;
		logic cc_seen;
		logic valid_flag;
		logic rp_flag;
		logic attach_flag;
		logic detach_flag;
		logic sum1;
		logic sum2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ccvb_state_type;

endpackage

// ### design/ccvb_bank.sv
// Behaviour
// - set compare-valid once, on first debounced cc load after the comparator is enabled
// - standalone sink: latch pull-up advertisement change pulses
// - other configurations: pull-up advertisement change bit reads zero, not settable
// - detach: source watches cc pins, sink watches vbus falling to safe zero
// - attach: source watches cc pins, sink needs cc attach and vbus present
// - attach and detach reported only in standalone mode
// - read-only per-pin summary bits flag changes of each cc change register
// - per pin eight change bits, set when same match bit toggles
// - change registers: write one clears a bit, zero leaves it
// - cc match bit set when voltage exceeds its programmed threshold
// - unattached: cc match updates after the unattached debounce interval
// - attach-wait or attached: cc match updates after the attached debounce interval
// - companion mode: cc match reads reset value until cc comparator enabled
// - debounced value where debounce-clear enable set, raw value otherwise
// - cc match resets to all ones for source role, zeros for sink
// - vbus_threshold_hits: levels 3..0 in bits 5..2, safe zero in bit 0
// - companion mode: vbus_threshold_hits reads zero until vbus comparator enabled
// - vbus_threshold_hits debounced per vbus debounce-clear enable
// - each toggling vbus_threshold_hits bit sets its vbus change bit
// - pulse-sourced event bits latch; cleared bit waits for a new pulse
// - device role zero is sink side, one is source side
// - debounce step is 1.6 ms with select zero, 100 us with one
`timescale 1ns/1ps
`default_nettype none
`include "ccvb_defines.svh"

module ccvb_bank
	import ccvb_pkg::*;
#(
	parameter int STEP_SLOW_CYC = `CCVB_STEP_SLOW_CYC,
	parameter int STEP_FAST_CYC = `CCVB_STEP_FAST_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] cc1_compare_raw,
	input wire logic [7:0] cc2_compare_raw,
	input wire logic [7:0] vbus_sense_input,
	input wire logic source_side_port,
	input wire logic standalone_mode,
	input wire logic cc_comparator_enable,
	input wire logic vbus_comparator_enable,
	input wire logic debounce_step_select,
	input wire logic [1:0] port_state,
	input wire logic [7:0] unattached_debounce_time,
	input wire logic [7:0] attached_debounce_time,
	input wire logic [7:0] cc1_debounce_clear_enable,
	input wire logic [7:0] cc2_debounce_clear_enable,
	input wire logic [7:0] vbus_debounce_clear_enable,
	input wire logic cc_attach_pulse,
	input wire logic cc_detach_pulse,
	input wire logic pullup_advert_pulse
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	ccvb_state_type state_ff;
	ccvb_state_type nxt_state;

	// last prescaler count of each step length; the prescaler wraps there
	localparam logic [16:0] SLOW_LAST = 17'(STEP_SLOW_CYC - 1);
	localparam logic [16:0] FAST_LAST = 17'(STEP_FAST_CYC - 1);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [13:0] idx;
		logic setup;
		logic wr;
		logic [7:0] clr;
		logic [7:0] interval;
		logic [7:0] mask;
		logic [7:0] held;
		logic [7:0] newv;
		logic [7:0] delta;
		logic hold;
		logic expire;
		logic cc_load;
		logic sink_standalone;
		logic attach_ev;
		logic detach_ev;
		logic [2:0][7:0] raw;
		logic [2:0][7:0] dbc_en;
		logic [31:0] rd;
		logic hit;
		logic wr_event;
		logic [2:0] wr_chg;
		idx = paddr[15:2];
		setup = psel && !penable;
		wr = psel && penable && state_ff.pready && pwrite;
		clr = pwdata[7:0] & {8{pstrb[0]}};
		interval = 8'h00;
		mask = 8'h00;
		held = 8'h00;
		newv = 8'h00;
		delta = 8'h00;
		hold = 1'b0;
		expire = 1'b0;
		cc_load = 1'b0;
		sink_standalone = standalone_mode && !source_side_port;
		attach_ev = 1'b0;
		detach_ev = 1'b0;
		raw = {vbus_sense_input & `CCVB_VBUS_MASK, cc2_compare_raw, cc1_compare_raw};
		dbc_en = {vbus_debounce_clear_enable, cc2_debounce_clear_enable,
			cc1_debounce_clear_enable};
		rd = 32'h0000_0000;
		hit = 1'b1;
		wr_event = wr && (idx == `CCVB_IDX_EVENT);
		wr_chg[0] = wr && (idx == `CCVB_IDX_CC1_CHG);
		wr_chg[1] = wr && (idx == `CCVB_IDX_CC2_CHG);
		wr_chg[2] = wr && (idx == `CCVB_IDX_VBUS_CHG);
		nxt_state = state_ff;

		// ----------------------------------------
		// input synchronisers
		// ----------------------------------------
		// comparator outputs are asynchronous to this clock; only the second
		// stage feeds the debouncers, so a metastable first stage never leaks
		nxt_state.sync1 = raw;
		nxt_state.sync2 = state_ff.sync1;

		// ----------------------------------------
		// debounce step generator
		// ----------------------------------------
		// one shared prescaler for all channels: a debounce may run up to one
		// step short, traded for a single counter instead of three
		nxt_state.tick = 1'b0;
		if (state_ff.prescale >= (debounce_step_select ? FAST_LAST : SLOW_LAST)) begin
			nxt_state.prescale = 17'h00000;
			nxt_state.tick = 1'b1;
		end else begin
			nxt_state.prescale = state_ff.prescale + 17'h00001;
		end

		// ----------------------------------------
		// debounce interval by port state
		// ----------------------------------------
		// attach-wait and both attached states share the pd interval; an
		// unknown code falls back to the unattached interval so that a
		// glitch on the state lines never freezes the match registers
		case (ccvb_port_state_type'(port_state))
			CCVB_PS_UNATTACHED: begin
				interval = unattached_debounce_time;
			end
			CCVB_PS_ATTACH_WAIT: begin
				interval = attached_debounce_time;
			end
			CCVB_PS_ATTACHED_SRC: begin
				interval = attached_debounce_time;
			end
			CCVB_PS_ATTACHED_SNK: begin
				interval = attached_debounce_time;
			end
			default: begin
				interval = unattached_debounce_time;
			end
		endcase

		// ----------------------------------------
		// match channels
		// ----------------------------------------
		// per channel: bits without debounce enable follow the synchronised
		// input, the others load only once the whole enabled group is steady
		for (int c = 0; c < 3; c++) begin
			mask = dbc_en[c];
			if (c == 2) begin
				hold = !standalone_mode && !vbus_comparator_enable;
				held = 8'h00;
			end else begin
				hold = !standalone_mode && !cc_comparator_enable;
				held = source_side_port ? `CCVB_HITS_SRC_RST : `CCVB_HITS_SNK_RST;
			end
			// raw bits pass straight through, debounced bits wait out the interval
			newv = (state_ff.hits[c] & mask) | (state_ff.sync2[c] & ~mask);
			expire = 1'b0;
			if ((state_ff.sync2[c] & mask) != (state_ff.target[c] & mask)) begin
				nxt_state.target[c] = state_ff.sync2[c];
				nxt_state.dbc_cnt[c] = 8'h00;
			end else if (((state_ff.hits[c] ^ state_ff.sync2[c]) & mask) != 8'h00) begin
				if (state_ff.dbc_cnt[c] >= interval) begin
					expire = 1'b1;
					newv = state_ff.sync2[c];
					nxt_state.dbc_cnt[c] = 8'h00;
				end else if (state_ff.tick) begin
					nxt_state.dbc_cnt[c] = state_ff.dbc_cnt[c] + 8'h01;
				end
			end
			// in companion mode a disabled comparator pins the register to its default; the step
			// into or out of that default still counts as a change
			if (hold) begin
				newv = held;
				expire = 1'b0;
				nxt_state.dbc_cnt[c] = 8'h00;
			end
			nxt_state.hits[c] = newv;
			if (c < 2 && expire) begin
				cc_load = 1'b1;
			end
			delta = newv ^ state_ff.hits[c];
			nxt_state.chg[c] = state_ff.chg[c];
			if (wr_chg[c]) begin
				nxt_state.chg[c] = state_ff.chg[c] & ~clr;
			end
			// set after clear: an event in the clearing cycle is kept
			nxt_state.chg[c] = nxt_state.chg[c] | delta;
		end

		// ----------------------------------------
		// event flags
		// ----------------------------------------
		// a sink has no cc detach of its own: loss of vbus, seen as the safe
		// zero match rising, ends the connection
		if (source_side_port) begin
			attach_ev = cc_attach_pulse;
			detach_ev = cc_detach_pulse;
		end else begin
			attach_ev = cc_attach_pulse && !state_ff.hits[2][`CCVB_VBUS_SAFE0];
			detach_ev = nxt_state.hits[2][`CCVB_VBUS_SAFE0]
				&& !state_ff.hits[2][`CCVB_VBUS_SAFE0];
		end
		// in companion mode the host runs attach detection itself
		attach_ev = attach_ev && standalone_mode;
		detach_ev = detach_ev && standalone_mode;

		// ----------------------------------------
		// write-one clears, applied before the sets so that a set wins
		// ----------------------------------------
		if (wr_event) begin
			if (clr[`CCVB_EV_VALID]) begin
				nxt_state.valid_flag = 1'b0;
			end
			if (clr[`CCVB_EV_RP]) begin
				nxt_state.rp_flag = 1'b0;
			end
			if (clr[`CCVB_EV_ATTACH]) begin
				nxt_state.attach_flag = 1'b0;
			end
			if (clr[`CCVB_EV_DETACH]) begin
				nxt_state.detach_flag = 1'b0;
			end
		end
		// ----------------------------------------
		// event sets
		// ----------------------------------------
		// compare-valid fires once per enable; later loads leave it alone so
		// software can clear it without it reappearing on every debounce
		if (cc_load && !state_ff.cc_seen) begin
			nxt_state.valid_flag = 1'b1;
			nxt_state.cc_seen = 1'b1;
		end
		// forget the first-match history while the comparator is off in companion mode
		if (!standalone_mode && !cc_comparator_enable) begin
			nxt_state.cc_seen = 1'b0;
		end
		// outside standalone sink the flag is held at zero, so a stale change
		// cannot surface when the port later becomes a standalone sink
		if (pullup_advert_pulse && sink_standalone) begin
			nxt_state.rp_flag = 1'b1;
		end
		if (!sink_standalone) begin
			nxt_state.rp_flag = 1'b0;
		end
		// the pulse sources do not persist, so the flags latch them
		if (attach_ev) begin
			nxt_state.attach_flag = 1'b1;
		end
		if (detach_ev) begin
			nxt_state.detach_flag = 1'b1;
		end

		// ----------------------------------------
		// per-pin summaries
		// ----------------------------------------
		// summary is not writable; it drops once its change register is empty
		if (nxt_state.chg[0] == 8'h00) begin
			nxt_state.sum1 = 1'b0;
		end
		if (nxt_state.chg[1] == 8'h00) begin
			nxt_state.sum2 = 1'b0;
		end
		if ((nxt_state.chg[0] & ~state_ff.chg[0]) != 8'h00) begin
			nxt_state.sum1 = 1'b1;
		end
		if ((nxt_state.chg[1] & ~state_ff.chg[1]) != 8'h00) begin
			nxt_state.sum2 = 1'b1;
		end

		// ----------------------------------------
		// apb slave, answer registered in setup so access has no wait state
		// ----------------------------------------
		case (idx)
			`CCVB_IDX_EVENT: begin
				rd[`CCVB_EV_VALID] = state_ff.valid_flag;
				rd[`CCVB_EV_RP] = state_ff.rp_flag && sink_standalone;
				rd[`CCVB_EV_DETACH] = state_ff.detach_flag;
				rd[`CCVB_EV_ATTACH] = state_ff.attach_flag;
				rd[`CCVB_EV_SUM2] = state_ff.sum2;
				rd[`CCVB_EV_SUM1] = state_ff.sum1;
			end
			// reads have no side effects, so reading a change register never
			// clears it; software must write ones back
			`CCVB_IDX_CC1_CHG: begin
				rd[7:0] = state_ff.chg[0];
			end
			`CCVB_IDX_CC2_CHG: begin
				rd[7:0] = state_ff.chg[1];
			end
			`CCVB_IDX_CC1_HITS: begin
				rd[7:0] = state_ff.hits[0];
			end
			`CCVB_IDX_CC2_HITS: begin
				rd[7:0] = state_ff.hits[1];
			end
			`CCVB_IDX_VBUS_HITS: begin
				rd[7:0] = state_ff.hits[2] & `CCVB_VBUS_MASK;
			end
			`CCVB_IDX_VBUS_CHG: begin
				rd[7:0] = state_ff.chg[2];
			end
			default: hit = 1'b0;
		endcase
		// the answer is latched at the setup edge, so every transfer takes
		// exactly one access cycle and pready never stretches
		nxt_state.pready = setup;
		if (setup) begin
			nxt_state.prdata = pwrite ? 32'h0000_0000 : rd;
			nxt_state.pslverr = !hit;
		end else if (!psel) begin
			nxt_state.prdata = 32'h0000_0000;
			nxt_state.pslverr = 1'b0;
		end

		// ----------------------------------------
		// synchronous reset
		// ----------------------------------------
		// the role is sampled while reset is high, so the cc match default
		// follows whatever role is presented at that time
		if (sys_rst) begin
			nxt_state = '0;
			nxt_state.hits[0] = source_side_port ? `CCVB_HITS_SRC_RST : `CCVB_HITS_SNK_RST;
			nxt_state.hits[1] = source_side_port ? `CCVB_HITS_SRC_RST : `CCVB_HITS_SNK_RST;
			nxt_state.target[0] = nxt_state.hits[0];
			nxt_state.target[1] = nxt_state.hits[1];
			nxt_state.chg = {3{`CCVB_CHG_RST}};
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		state_ff <= nxt_state;
	end

	// ----------------------------------------
	// outputs, straight from the state register
	// ----------------------------------------
	assign prdata = state_ff.prdata;
	assign pready = state_ff.pready;
	assign pslverr = state_ff.pslverr;

endmodule // ccvb_bank

`default_nettype wire

// ### verif/ccvb_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// apb timing and readback checks
// ----------------------------------------
module ccvb_bank_asserts (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic source_side_port,
	input wire logic standalone_mode,
	input wire logic cc_comparator_enable,
	input wire logic vbus_comparator_enable
);
	logic [13:0] idx;
	logic rd;
	assign idx = paddr[15:2];
	assign rd = pready && psel && penable && !pwrite;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	unmapped_err_a: assert property (pready |-> pslverr == (idx < 14'h803 || idx > 14'h809))
		else $error("slave error wrong");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	vbus_reserved_a: assert property (
		rd && idx == 14'h808 |-> (prdata[7:0] & 8'hc2) == 8'h00) else $error("vbus reserved set");
	event_reserved_a: assert property (rd && idx == 14'h803 |-> prdata[3:2] == 2'b00 &&
		(!prdata[6] || (standalone_mode && !source_side_port))) else $error("event bits wrong");
	cc_held_a: assert property (rd && (idx == 14'h806 || idx == 14'h807) &&
		!standalone_mode && !$past(standalone_mode, 4) && !cc_comparator_enable &&
		!$past(cc_comparator_enable, 4) && source_side_port == $past(source_side_port, 4)
		|-> prdata[7:0] == {8{source_side_port}}) else $error("cc hits not reset value");
	vbus_held_a: assert property (rd && idx == 14'h808 && !standalone_mode &&
		!$past(standalone_mode, 4) && !vbus_comparator_enable && !$past(vbus_comparator_enable, 4)
		|-> prdata[7:0] == 8'h00) else $error("vbus hits not zero");
	cover property (rd && idx == 14'h803);
	cover property (pready && pwrite && idx == 14'h804);
	cover property (pready && pslverr);
endmodule // ccvb_bank_asserts

bind ccvb_bank ccvb_bank_asserts chk_u (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .source_side_port, .standalone_mode, .cc_comparator_enable,
	.vbus_comparator_enable);
`default_nettype wire

// ### verif/ccvb_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccvb_defines.svh"
module ccvb_bank_tb_top;
	logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr;
	logic [7:0] cc1_compare_raw = 8'h0, cc2_compare_raw = 8'h0, vbus_sense_input = 8'h0;
	logic source_side_port = 1'b1, standalone_mode = 1'b0, cc_comparator_enable = 1'b0;
	logic vbus_comparator_enable = 1'b0, debounce_step_select = 1'b1;
	logic [1:0] port_state = 2'h0;
	logic [7:0] unattached_debounce_time = 8'h3, attached_debounce_time = 8'h3;
	logic [7:0] cc1_debounce_clear_enable = 8'h0, cc2_debounce_clear_enable = 8'h0;
	logic [7:0] vbus_debounce_clear_enable = 8'h0;
	logic cc_attach_pulse = 1'b0, cc_detach_pulse = 1'b0, pullup_advert_pulse = 1'b0;
	logic [32:0] expq[$];
	logic [7:0] mskq[$];
	logic [7:0] v, w, d;
	int miscompares = 0, samples_checked = 0;

	// ----------------------------------------
	// short step counts keep debounce runs brief
	// ----------------------------------------
	ccvb_bank #(.STEP_SLOW_CYC(8), .STEP_FAST_CYC(4)) dut_u (.clock, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cc1_compare_raw,
		.cc2_compare_raw, .vbus_sense_input, .source_side_port, .standalone_mode,
		.cc_comparator_enable, .vbus_comparator_enable, .debounce_step_select, .port_state,
		.unattached_debounce_time, .attached_debounce_time, .cc1_debounce_clear_enable,
		.cc2_debounce_clear_enable, .vbus_debounce_clear_enable, .cc_attach_pulse,
		.cc_detach_pulse, .pullup_advert_pulse);

	initial forever #10 clock = ~clock;

	task automatic chk(input logic [13:0] i, input logic [32:0] got, input logic [32:0] e);
		samples_checked++;
		if (got !== e) begin
			miscompares++;
			$display("BAD reg %h exp %h got %h", i, e, got);
		end
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// apb master; the trailing edge stops a same-step re-drive of psel
	// ----------------------------------------
	task automatic apb(input logic wr_, input logic [13:0] i, input logic [31:0] dat,
		input logic [32:0] e, input logic [7:0] mk);
		psel <= 1'b1;
		pwrite <= wr_;
		paddr <= {i, 2'b00};
		pwdata <= dat;
		if (!wr_) begin
			expq.push_back(e);
			mskq.push_back(mk);
		end
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock iff pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [13:0] i, input logic [7:0] e, input logic [7:0] mk);
		apb(1'b0, i, 32'h0, {25'h0, e & mk}, mk);
	endtask

	task automatic wr(input logic [13:0] i, input logic [7:0] dat);
		apb(1'b1, i, {24'h0, dat}, 33'h0, 8'h0);
	endtask

	task automatic rst(input logic role);
		sys_rst <= 1'b1;
		source_side_port <= role;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
	endtask

	task automatic pls(input logic [2:0] p);
		{pullup_advert_pulse, cc_detach_pulse, cc_attach_pulse} <= p;
		@(posedge clock);
		{pullup_advert_pulse, cc_detach_pulse, cc_attach_pulse} <= 3'h0;
		repeat (2) @(posedge clock);
	endtask

	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk(paddr[15:2], {pslverr, prdata[31:8], prdata[7:0] & mskq[0]}, expq[0]);
			void'(expq.pop_front());
			void'(mskq.pop_front());
		end
	end

	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h377b));
		for (int r = 1; r >= 0; r--) begin
			rst(r[0]);
			rd(`CCVB_IDX_CC1_HITS, {8{r[0]}}, 8'hff);
			rd(`CCVB_IDX_CC2_HITS, {8{r[0]}}, 8'hff);
			rd(`CCVB_IDX_VBUS_HITS, 8'h00, 8'hff);
			rd(`CCVB_IDX_CC1_CHG, 8'h00, 8'hff);
		end
		v = 8'($urandom) | 8'h80;
		w = 8'($urandom) & 8'hfe;
		d = 8'($urandom);
		cc1_compare_raw <= v;
		vbus_sense_input <= w;
		standalone_mode <= 1'b1;
		cc_comparator_enable <= 1'b1;
		vbus_comparator_enable <= 1'b1;
		repeat (8) @(posedge clock);
		rd(`CCVB_IDX_CC1_HITS, v, 8'hff);
		rd(`CCVB_IDX_CC1_CHG, v, 8'hff);
		rd(`CCVB_IDX_EVENT, 8'h01, 8'h83);
		rd(`CCVB_IDX_VBUS_HITS, w & 8'h3d, 8'hff);
		rd(`CCVB_IDX_VBUS_CHG, w & 8'h3d, 8'hff);
		wr(`CCVB_IDX_CC1_CHG, d);
		rd(`CCVB_IDX_CC1_CHG, v & ~d, 8'hff);
		wr(`CCVB_IDX_CC1_CHG, 8'hff);
		rd(`CCVB_IDX_EVENT, 8'h00, 8'h83);
		wr(`CCVB_IDX_VBUS_CHG, 8'hff);
		rd(`CCVB_IDX_VBUS_CHG, 8'h00, 8'hff);
		apb(1'b0, 14'h080a, 32'h0, {1'b1, 32'h0}, 8'hff);
		wr(14'h0802, 8'hff);
		for (int ps = 0; ps < 2; ps++) begin
			port_state <= 2'(ps);
			debounce_step_select <= (ps == 0);
			unattached_debounce_time <= ps ? 8'hff : 8'h03;
			attached_debounce_time <= ps ? 8'h03 : 8'hff;
			cc2_debounce_clear_enable <= 8'hff;
			cc2_compare_raw <= ps ? 8'h3c : 8'h5a;
			repeat (4) @(posedge clock);
			rd(`CCVB_IDX_CC2_HITS, ps ? 8'h5a : 8'h00, 8'hff);
			repeat (30) @(posedge clock);
			rd(`CCVB_IDX_CC2_HITS, ps ? 8'h3c : 8'h5a, 8'hff);
		end
		rd(`CCVB_IDX_EVENT, 8'h80, 8'h80);
		pls(3'h7);
		rd(`CCVB_IDX_EVENT, 8'h50, 8'h70);
		vbus_sense_input <= 8'h01;
		repeat (6) @(posedge clock);
		rd(`CCVB_IDX_EVENT, 8'h70, 8'h70);
		wr(`CCVB_IDX_EVENT, 8'h70);
		rd(`CCVB_IDX_EVENT, 8'h00, 8'h70);
		source_side_port <= 1'b1;
		pls(3'h7);
		rd(`CCVB_IDX_EVENT, 8'h30, 8'h70);
		wr(`CCVB_IDX_EVENT, 8'h70);
		standalone_mode <= 1'b0;
		pls(3'h7);
		rd(`CCVB_IDX_EVENT, 8'h00, 8'h70);
		source_side_port <= 1'b0;
		cc_comparator_enable <= 1'b0;
		vbus_comparator_enable <= 1'b0;
		repeat (8) @(posedge clock);
		rd(`CCVB_IDX_CC1_HITS, 8'h00, 8'hff);
		rd(`CCVB_IDX_VBUS_HITS, 8'h00, 8'hff);
		tally_and_finish();
	end
endmodule // ccvb_bank_tb_top
`default_nettype wire
